// ### bench/mpf_ts_sink.sv
// Downstream stream sink standing in for the link to the exciters
`timescale 1ns/1ps
module mpf_ts_sink (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic slow_in,
    input wire logic valid_in,
    input wire logic sop_in,
    input wire logic [7:0] data_in,
    output logic ready_out
);
    logic [7:0] pkt [188];
    int cnt = 0;
    int npk = 0;
    int sop_bad = 0;
    // Random stalls on about one cycle in four, when slow_in is set, keep some bytes standing on the wire for a while
    always @(posedge clk_in) begin
        ready_out <= !rst_n_in ? 1'b0 : (!slow_in || ($urandom % 4 != 0));
        if (rst_n_in && valid_in && ready_out) begin
            if (sop_in !== (cnt == 0)) sop_bad <= sop_bad + 1;
            pkt[cnt] <= data_in;
            cnt <= (cnt == 187) ? 0 : cnt + 1;
            if (cnt == 187) npk <= npk + 1;
        end
    end
endmodule : mpf_ts_sink

// ### bench/tb_maintenance_packet_framer_release_timing.sv
// Self-checking bench for the maintenance packet framer
`timescale 1ns/1ps
module tb_maintenance_packet_framer_release_timing;
    import mpf_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, gps_s = 0, body [46];
    logic pready, pslverr, gps_v = 0, pps = 0, tick = 0, slow = 0;
    logic ts_valid, ts_sop, ts_ready, rel_pulse, frm;
    logic [7:0] ts_data, typ, o, v0, v1;
    int err_total = 0, cmp_count = 0, i, k, n0, tcnt = 0;
    longint cyc = 0, t0 = -1, rel_cyc = -1, frm_cnt = -1, s, md;

    mpf_framer u_dut (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .GPS_SECS_IN(gps_s), .GPS_SECS_VALID_IN(gps_v),
        .GPS_PPS_IN(pps), .TS_PKT_TICK_IN(tick), .TS_READY_IN(ts_ready), .TS_DATA_OUT(ts_data),
        .TS_VALID_OUT(ts_valid), .TS_SOP_OUT(ts_sop), .CADENCE_RELEASE_OUT(rel_pulse), .FRAME_BOUNDARY_OUT(frm));
    mpf_ts_sink u_sink (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .valid_in(ts_valid),
        .sop_in(ts_sop), .data_in(ts_data), .ready_out(ts_ready));

    initial begin
        forever #25 clk = ~clk;
    end

    // Cycle count, tick instant, release instant and hang guard
    always @(posedge clk) begin
        // Packet slots counted from the release; it restarts the numbering
        if (rel_pulse === 1'b1) begin
            if (rel_cyc < 0) rel_cyc = cyc;
            tcnt = 0;
        end else if (tick === 1'b1) begin
            tcnt++;
        end
        if (frm === 1'b1 && rel_pulse !== 1'b1 && rel_cyc >= 0 && frm_cnt < 0) frm_cnt = tcnt;
        if (pps && t0 < 0) t0 = cyc;
        // Short slots so a whole cadence period fits in the run
        tick <= (cyc % 16 == 0);
        cyc = cyc + 1;
        if (cyc == 95000) begin
            err_total++;
            end_of_test();
        end
    end

    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    function automatic logic [7:0] exp_b(int n, logic [3:0] cc, logic [7:0] ty, logic te);
        case (n)
            0: return 8'h47;
            1: return {te, 2'b11, 5'h1f};
            2: return 8'hfa;
            3: return {2'b00, 2'b01, cc};
            4: return ty;
            default: return (n - 5 == o) ? v1 : body[(n - 5) / 4][8 * ((n - 5) % 4) +: 8];
        endcase
    endfunction : exp_b

    // Release offset in clock cycles after the tick that carried sec
    function automatic longint rel_exp(longint sec, longint dly);
        longint r;
        r = (sec * 4809375 + 4654935) % 4654936;
        return (4654935 - r) * 20000000 / 4809375 - dly * 223795 * 2 / 433998;
    endfunction : rel_exp

    initial begin
        void'($urandom(32'h96dda164));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, 12'h000, 0);
        chk(rd, 0, "ctrl reset");
        apb(0, 12'h008, 0);
        chk(rd, 0, "delay reset");
        apb(0, 12'h040, 0);
        chk({31'h0, err}, 1, "unmapped error");
        chk(rd, 0, "unmapped read");
        for (i = 0; i < 46; i++) begin
            body[i] = $urandom;
            apb(1, 12'h100 + 12'(4 * i), body[i]);
        end
        o = 8'($urandom % 183);
        v0 = 8'($urandom);
        v1 = ~v0;
        apb(1, 12'h010, {15'h0, 1'b1, v0, o});
        apb(1, 12'h014, {15'h0, 1'b1, v1, o});
        md = $urandom % 3000;
        apb(1, 12'h008, md[31:0]);
        typ = 8'($urandom % 32);
        apb(1, 12'h004, {24'h0, typ});
        slow <= 1'b1;
        apb(1, 12'h000, 32'h5);
        repeat (40) @(posedge clk);
        chk({31'h0, ts_valid}, 0, "packet before time valid");
        $display("test idle before time done");
        // Seconds near the top of the range stress the wide arithmetic
        s = 64'hf0000000 | ($urandom & 32'h0fffffff);
        // Release must fall after the packet tests, and seconds stay 32 bits
        while (rel_exp(s, md) < 15000 || rel_exp(s, md) > 40000) s = (s + 1) & 64'hffffffff;
        gps_s <= s[31:0];
        gps_v <= 1'b1;
        repeat (5) @(posedge clk);
        pps <= 1'b1;
        repeat (10) @(posedge clk);
        pps <= 1'b0;
        for (k = 0; k < 17; k++) begin
            n0 = u_sink.npk;
            if (k > 0) begin
                typ = 8'($urandom % 32);
                apb(1, 12'h004, {24'h0, typ});
                apb(1, 12'h004, 32'h20 + $urandom % 224);
                apb(0, 12'h004, 0);
                chk(rd, {24'h0, typ}, "reserved code refused");
                apb(1, 12'h000, {29'h0, 1'b1, k[0], 1'b1});
            end
            for (i = 0; i < 3000 && u_sink.npk == n0; i++) @(posedge clk);
            for (i = 0; i < 188; i++) begin
                chk(u_sink.pkt[i], exp_b(i, k[3:0], typ, k[0]), "packet byte");
            end
        end
        chk(u_sink.sop_bad, 0, "start marker");
        $display("test packets done");
        apb(1, 12'h000, 32'h9);
        n0 = u_sink.npk;
        for (i = 0; i < 60000 && rel_cyc < 0; i++) @(posedge clk);
        chk(32'(rel_cyc - t0 >= rel_exp(s, md) - 1 && rel_cyc - t0 <= rel_exp(s, md) + 5), 1, "release");
        for (i = 0; i < 3000 && u_sink.npk == n0; i++) @(posedge clk);
        chk(u_sink.npk - n0, 1, "auto send on release");
        for (i = 0; i < 188; i++) begin
            chk(u_sink.pkt[i], exp_b(i, 4'h1, typ, 1'b0), "auto packet byte");
        end
        apb(0, 12'h018, 0);
        chk(rd, s[31:0], "seconds latched");
        apb(0, 12'h01c, 0);
        chk(rd, 32'(rel_exp(s, md)), "release offset");
        $display("test release done");
        for (i = 0; i < 12000 && frm_cnt < 0; i++) @(posedge clk);
        chk(32'(frm_cnt), 32'(CADENCE_PERIOD - FRAME_LEAD), "frame lead");
        $display("test frame boundary done");
        end_of_test();
    end
endmodule : tb_maintenance_packet_framer_release_timing

// ### design/mpf_framer.sv
// Maintenance packet framer with cadence point release timing
`timescale 1ns/1ps
module mpf_framer (
    input wire logic SYS_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic [31:0] GPS_SECS_IN,
    input wire logic GPS_SECS_VALID_IN,
    input wire logic GPS_PPS_IN,
    input wire logic TS_PKT_TICK_IN,
    input wire logic TS_READY_IN,
    output logic [7:0] TS_DATA_OUT,
    output logic TS_VALID_OUT,
    output logic TS_SOP_OUT,
    output logic CADENCE_RELEASE_OUT,
    output logic FRAME_BOUNDARY_OUT
);
    import mpf_pkg::*;

    // Time reference synchronisers
    logic [31:0] secs_s1_q, secs_s2_q;
    logic vld_s1_q, vld_s2_q, pps_s1_q, pps_s2_q, pps_s3_q;
    logic pps_rise;
    // Registers
    logic [3:0] ctrl_q, ctrl_d;
    logic [7:0] type_q, type_d;
    logic [DLY_W-1:0] maxdly_q, maxdly_d;
    mpf_sub_t sub0_q, sub0_d, sub1_q, sub1_d;
    logic [31:0] body_mem [0:BODY_WORDS-1];
    logic [31:0] prdata_q, prdata_d;
    logic slverr_q, slverr_d;
    logic apb_wr, apb_setup, send_req;
    // Timing
    mpf_calc_t calc_q, calc_d;
    logic [CALC_W-1:0] div_num_q, div_num_d, div_quo_q, div_quo_d;
    logic [31:0] div_den_q, div_den_d, div_rem_q, div_rem_d;
    logic [5:0] div_cnt_q, div_cnt_d;
    logic [32:0] rem_sh, rem_nx;
    logic [CALC_W-1:0] quo_nx;
    logic sub_ok;
    logic [31:0] secs_q, secs_d, tick_cyc_q, tick_cyc_d, rel_off_q, rel_off_d;
    logic [31:0] elapsed_q, elapsed_d;
    logic rel_arm_q, rel_arm_d, late_q, late_d, gps_ok_q, gps_ok_d, cad_q, cad_d;
    logic [9:0] pkt_num_q, pkt_num_d;
    logic frame_q, frame_d;
    // Packet transmit
    mpf_tx_t tx_q, tx_d;
    logic [7:0] idx_q, idx_d, data_q, data_d, nxt_idx, nxt_byte, body_idx;
    logic [3:0] cc_q, cc_d;
    logic pend_q, pend_d;
    mpf_hdr_t hdr;
    logic [31:0] body_word;

    // Second flop feeds logic, and on PPS the third too for the edge; seconds bus assumed stable around the tick
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            secs_s1_q <= 32'h0;
            secs_s2_q <= 32'h0;
            vld_s1_q <= 1'b0;
            vld_s2_q <= 1'b0;
            pps_s1_q <= 1'b0;
            pps_s2_q <= 1'b0;
            pps_s3_q <= 1'b0;
        end else begin
            secs_s1_q <= GPS_SECS_IN;
            secs_s2_q <= secs_s1_q;
            vld_s1_q <= GPS_SECS_VALID_IN;
            vld_s2_q <= vld_s1_q;
            pps_s1_q <= GPS_PPS_IN;
            pps_s2_q <= pps_s1_q;
            pps_s3_q <= pps_s2_q;
        end
    end
    assign pps_rise = pps_s2_q && !pps_s3_q;

    // APB slave, zero wait states
    assign apb_setup = PSEL_IN && !PENABLE_IN;
    assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign send_req = apb_wr && (PADDR_IN == ADDR_CTRL) && PWDATA_IN[CTRL_SEND];
    assign PREADY_OUT = 1'b1;
    assign PRDATA_OUT = prdata_q;
    assign PSLVERR_OUT = slverr_q;

    always_comb begin
        ctrl_d = ctrl_q;
        type_d = type_q;
        maxdly_d = maxdly_q;
        sub0_d = sub0_q;
        sub1_d = sub1_q;
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        if (apb_wr) begin
            unique case (PADDR_IN)
                ADDR_CTRL: ctrl_d = {PWDATA_IN[CTRL_AUTO], 1'b0, PWDATA_IN[CTRL_FRSC], PWDATA_IN[CTRL_ENABLE]};
                // Reserved codes above the control range are refused
                ADDR_TYPE: if (PWDATA_IN[7:0] <= TYPE_CTRL_MAX) type_d = PWDATA_IN[7:0];
                ADDR_MAXDLY: maxdly_d = PWDATA_IN[DLY_W-1:0];
                ADDR_SUB0: sub0_d = PWDATA_IN[16:0];
                ADDR_SUB1: sub1_d = PWDATA_IN[16:0];
                default: ;
            endcase
        end
        if (apb_setup) begin
            slverr_d = 1'b0;
            prdata_d = 32'h0;
            if (PADDR_IN >= ADDR_BODY && PADDR_IN < ADDR_BODY + 12'(4 * BODY_WORDS) && PADDR_IN[1:0] == 2'h0) begin
                prdata_d = body_mem[6'((PADDR_IN - ADDR_BODY) >> 2)];
            end else begin
                unique case (PADDR_IN)
                    ADDR_CTRL: prdata_d = {28'h0, ctrl_q};
                    ADDR_TYPE: prdata_d = {24'h0, type_q};
                    ADDR_MAXDLY: prdata_d = {7'h0, maxdly_q};
                    ADDR_STATUS: prdata_d = {12'h0, cc_q, 2'h0, pkt_num_q, late_q, pend_q, tx_q == TX_SEND, gps_ok_q};
                    ADDR_SUB0: prdata_d = {15'h0, sub0_q};
                    ADDR_SUB1: prdata_d = {15'h0, sub1_q};
                    ADDR_GPSSEC: prdata_d = secs_q;
                    ADDR_RELOFF: prdata_d = rel_off_q;
                    default: slverr_d = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            ctrl_q <= CTRL_RESET;
            type_q <= TYPE_RESET;
            maxdly_q <= MAXDLY_RESET;
            sub0_q <= '0;
            sub1_q <= '0;
            prdata_q <= 32'h0;
            slverr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            type_q <= type_d;
            maxdly_q <= maxdly_d;
            sub0_q <= sub0_d;
            sub1_q <= sub1_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    // Fixed body values loaded from upstream software
    always_ff @(posedge SYS_CLK_IN) begin
        if (apb_wr && PADDR_IN >= ADDR_BODY && PADDR_IN < ADDR_BODY + 12'(4 * BODY_WORDS)) begin
            body_mem[6'((PADDR_IN - ADDR_BODY) >> 2)] <= PWDATA_IN;
        end
    end

    // Shared restoring divider runs three quotients per tick, 64 steps each
    always_comb begin
        rem_sh = {div_rem_q, div_num_q[CALC_W-1]};
        sub_ok = rem_sh >= {1'b0, div_den_q};
        rem_nx = sub_ok ? rem_sh - {1'b0, div_den_q} : rem_sh;
        quo_nx = {div_quo_q[CALC_W-2:0], sub_ok};
        calc_d = calc_q;
        div_num_d = div_num_q;
        div_den_d = div_den_q;
        div_rem_d = div_rem_q;
        div_quo_d = div_quo_q;
        div_cnt_d = div_cnt_q;
        secs_d = secs_q;
        tick_cyc_d = tick_cyc_q;
        rel_off_d = rel_off_q;
        rel_arm_d = rel_arm_q;
        late_d = late_q;
        gps_ok_d = gps_ok_q || (pps_rise && vld_s2_q);
        elapsed_d = pps_rise ? 32'h0 : elapsed_q + 32'h1;
        cad_d = 1'b0;
        if (rel_arm_q && elapsed_q == rel_off_q) begin
            cad_d = 1'b1;
            rel_arm_d = 1'b0;
        end
        unique case (calc_q)
            C_IDLE: begin
                if (pps_rise && vld_s2_q) begin
                    secs_d = secs_s2_q;
                    div_num_d = CALC_W'(64'(secs_s2_q) * 64'(AT_DEN) + 64'(AT_NUM - 1));
                    div_den_d = 32'(AT_NUM);
                    div_rem_d = 32'h0;
                    div_quo_d = '0;
                    div_cnt_d = 6'h0;
                    calc_d = C_CEIL;
                end
            end
            C_CEIL, C_TICK, C_MDLY: begin
                div_num_d = {div_num_q[CALC_W-2:0], 1'b0};
                div_rem_d = rem_nx[31:0];
                div_quo_d = quo_nx;
                div_cnt_d = div_cnt_q + 6'h1;
                if (div_cnt_q == 6'h3f) begin
                    div_rem_d = 32'h0;
                    div_quo_d = '0;
                    div_cnt_d = 6'h0;
                    if (calc_q == C_CEIL) begin
                        // Tick minus seconds is (N-1-r)/D, no multiply by k needed
                        div_num_d = CALC_W'((64'(AT_NUM - 1) - 64'(rem_nx[31:0])) * 64'(CLK_HZ));
                        div_den_d = 32'(AT_DEN);
                        calc_d = C_TICK;
                    end else if (calc_q == C_TICK) begin
                        tick_cyc_d = quo_nx[31:0];
                        div_num_d = CALC_W'(64'(maxdly_q) * 64'(DLY_NUM) * 64'(DLY_SCALE));
                        div_den_d = 32'(DLY_DEN);
                        calc_d = C_MDLY;
                    end else begin
                        calc_d = C_IDLE;
                        if (tick_cyc_q >= quo_nx[31:0] && tick_cyc_q - quo_nx[31:0] > elapsed_q) begin
                            rel_off_d = tick_cyc_q - quo_nx[31:0];
                            rel_arm_d = 1'b1;
                            late_d = 1'b0;
                        end else begin
                            // Release point already passed; only the late flag is set
                            late_d = 1'b1;
                        end
                    end
                end
            end
            default: calc_d = C_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            calc_q <= C_IDLE;
            div_num_q <= '0;
            div_den_q <= 32'h0;
            div_rem_q <= 32'h0;
            div_quo_q <= '0;
            div_cnt_q <= 6'h0;
            secs_q <= 32'h0;
            tick_cyc_q <= 32'h0;
            rel_off_q <= 32'h0;
            rel_arm_q <= 1'b0;
            late_q <= 1'b0;
            gps_ok_q <= 1'b0;
            elapsed_q <= 32'h0;
            cad_q <= 1'b0;
        end else begin
            calc_q <= calc_d;
            div_num_q <= div_num_d;
            div_den_q <= div_den_d;
            div_rem_q <= div_rem_d;
            div_quo_q <= div_quo_d;
            div_cnt_q <= div_cnt_d;
            secs_q <= secs_d;
            tick_cyc_q <= tick_cyc_d;
            rel_off_q <= rel_off_d;
            rel_arm_q <= rel_arm_d;
            late_q <= late_d;
            gps_ok_q <= gps_ok_d;
            elapsed_q <= elapsed_d;
            cad_q <= cad_d;
        end
    end
    assign CADENCE_RELEASE_OUT = cad_q;

    // Packet numbering from each cadence point
    always_comb begin
        pkt_num_d = pkt_num_q;
        frame_d = 1'b0;
        if (cad_q) begin
            pkt_num_d = 10'h0;
        end else if (TS_PKT_TICK_IN) begin
            pkt_num_d = (pkt_num_q == 10'(CADENCE_PERIOD - 1)) ? 10'h0 : pkt_num_q + 10'h1;
            // Pulse with the packet that opens the lead, not one after it
            frame_d = pkt_num_q == 10'(CADENCE_PERIOD - FRAME_LEAD - 1);
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            pkt_num_q <= 10'h0;
            frame_q <= 1'b0;
        end else begin
            pkt_num_q <= pkt_num_d;
            frame_q <= frame_d;
        end
    end
    assign FRAME_BOUNDARY_OUT = frame_q;

    // Byte builder
    always_comb begin
        hdr.tei = ctrl_q[CTRL_FRSC];
        hdr.pusi = 1'b1;
        hdr.prio = 1'b1;
        hdr.pid = PID_VALUE;
        hdr.scr = SCR_VALUE;
        hdr.afc = AFC_VALUE;
        hdr.cc = cc_q;
        nxt_idx = (tx_q == TX_SEND) ? idx_q + 8'h1 : 8'h0;
        body_idx = nxt_idx - 8'(HDR_BYTES + 1);
        body_word = body_mem[6'(body_idx >> 2)];
        nxt_byte = body_word[8 * body_idx[1:0] +: 8];
        // Second substitution overrides the first on a shared offset
        if (sub0_q.en && sub0_q.offset == body_idx) nxt_byte = sub0_q.value;
        if (sub1_q.en && sub1_q.offset == body_idx) nxt_byte = sub1_q.value;
        unique case (nxt_idx)
            8'h00: nxt_byte = SYNC_BYTE;
            8'h01: nxt_byte = hdr[23:16];
            8'h02: nxt_byte = hdr[15:8];
            8'h03: nxt_byte = hdr[7:0];
            8'h04: nxt_byte = type_q;
            default: ;
        endcase
    end

    // Transmit sequencer; a request arriving with the start is kept
    always_comb begin
        tx_d = tx_q;
        idx_d = idx_q;
        data_d = data_q;
        cc_d = cc_q;
        pend_d = pend_q;
        unique case (tx_q)
            TX_IDLE: begin
                if (pend_q && gps_ok_q && ctrl_q[CTRL_ENABLE]) begin
                    tx_d = TX_SEND;
                    idx_d = 8'h0;
                    data_d = nxt_byte;
                    pend_d = 1'b0;
                end
            end
            TX_SEND: begin
                if (TS_READY_IN) begin
                    if (idx_q == 8'(PKT_BYTES - 1)) begin
                        tx_d = TX_IDLE;
                        cc_d = cc_q + 4'h1;
                    end else begin
                        idx_d = nxt_idx;
                        data_d = nxt_byte;
                    end
                end
            end
        endcase
        if (send_req || (cad_q && ctrl_q[CTRL_AUTO])) pend_d = 1'b1;
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            tx_q <= TX_IDLE;
            idx_q <= 8'h0;
            data_q <= 8'h0;
            cc_q <= 4'h0;
            pend_q <= 1'b0;
        end else begin
            tx_q <= tx_d;
            idx_q <= idx_d;
            data_q <= data_d;
            cc_q <= cc_d;
            pend_q <= pend_d;
        end
    end
    assign TS_DATA_OUT = data_q;
    assign TS_VALID_OUT = tx_q == TX_SEND;
    assign TS_SOP_OUT = (tx_q == TX_SEND) && idx_q == 8'h0;

    // Checks
    sequence byte_at(int n);
        TS_VALID_OUT && idx_q == 8'(n);
    endsequence
    sequence pkt_end;
        TS_VALID_OUT && TS_READY_IN && idx_q == 8'(PKT_BYTES - 1);
    endsequence
    chk_sync_byte: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        byte_at(0) |-> TS_DATA_OUT == SYNC_BYTE && TS_SOP_OUT) else $error("sync byte wrong");
    chk_pid_flags: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        byte_at(1) |-> TS_DATA_OUT == {ctrl_q[CTRL_FRSC], 2'b11, PID_VALUE[12:8]}) else $error("pid high wrong");
    chk_pid_low: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        byte_at(2) |-> TS_DATA_OUT == PID_VALUE[7:0]) else $error("pid low wrong");
    chk_tei_zero: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        byte_at(1) ##0 !ctrl_q[CTRL_FRSC] |-> !TS_DATA_OUT[7]) else $error("error bit set");
    chk_hdr_tail: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        byte_at(3) |-> TS_DATA_OUT == {SCR_VALUE, AFC_VALUE, cc_q}) else $error("header tail wrong");
    chk_type_byte: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        byte_at(4) |-> TS_DATA_OUT == type_q && TS_DATA_OUT <= TYPE_CTRL_MAX) else $error("type code wrong");
    chk_cc_step: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        pkt_end |=> !TS_VALID_OUT && cc_q == $past(cc_q) + 4'h1) else $error("counter step wrong");
    chk_gps_gate: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        TS_VALID_OUT |-> gps_ok_q) else $error("packet before gps");
    chk_calc_bound: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        calc_q == C_IDLE && pps_rise && vld_s2_q |=> calc_q == C_CEIL ##192 calc_q == C_IDLE)
        else $error("timing calc length wrong");
    chk_release_time: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        $rose(cad_q) |-> $past(elapsed_q) == rel_off_q && !rel_arm_q) else $error("release off target");
    chk_frame_lead: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        frame_q |-> pkt_num_q == 10'(CADENCE_PERIOD - FRAME_LEAD)) else $error("frame lead wrong");
    chk_cadence_wrap: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        pkt_num_q < 10'(CADENCE_PERIOD)) else $error("packet number out of range");
endmodule : mpf_framer

// ### shared/mpf_pkg.sv
// Constants, types and register map for the maintenance packet framer
package mpf_pkg;
    localparam logic [12:0] PID_VALUE = 13'h1ffa;
    localparam logic [7:0] SYNC_BYTE = 8'h47;
    localparam logic [1:0] SCR_VALUE = 2'h0;
    localparam logic [1:0] AFC_VALUE = 2'h1;
    localparam int HDR_BYTES = 4;
    localparam int PAYLOAD_BYTES = 184;
    localparam int BODY_BYTES = 183;
    localparam int PKT_BYTES = HDR_BYTES + PAYLOAD_BYTES;
    localparam int BODY_WORDS = (BODY_BYTES + 3) / 4;
    localparam logic [7:0] TYPE_CTRL_MAX = 8'h1f;
    localparam int CADENCE_PERIOD = 624;
    localparam int FRAME_LEAD = 37;
    localparam longint AT_NUM = 4654936;
    localparam longint AT_DEN = 4809375;
    localparam longint DLY_NUM = 223795;
    localparam longint DLY_DEN = 433998;
    localparam longint CLK_HZ = 20000000;
    localparam longint DLY_UNIT_HZ = 10000000;
    localparam longint DLY_SCALE = CLK_HZ / DLY_UNIT_HZ;
    localparam int CALC_W = 64;
    localparam int DLY_W = 25;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_TYPE = 12'h004;
    localparam logic [11:0] ADDR_MAXDLY = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    localparam logic [11:0] ADDR_SUB0 = 12'h010;
    localparam logic [11:0] ADDR_SUB1 = 12'h014;
    localparam logic [11:0] ADDR_GPSSEC = 12'h018;
    localparam logic [11:0] ADDR_RELOFF = 12'h01c;
    localparam logic [11:0] ADDR_BODY = 12'h100;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_FRSC = 1;
    localparam int CTRL_SEND = 2;
    localparam int CTRL_AUTO = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [7:0] TYPE_RESET = 8'h00;
    localparam logic [DLY_W-1:0] MAXDLY_RESET = 25'h0000000;
    typedef struct packed {
        logic tei;
        logic pusi;
        logic prio;
        logic [12:0] pid;
        logic [1:0] scr;
        logic [1:0] afc;
        logic [3:0] cc;
    } mpf_hdr_t;
    typedef struct packed {
        logic en;
        logic [7:0] value;
        logic [7:0] offset;
    } mpf_sub_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } mpf_tx_t;
    typedef enum logic [3:0] {
        C_IDLE = 4'b0001,
        C_CEIL = 4'b0010,
        C_TICK = 4'b0100,
        C_MDLY = 4'b1000
    } mpf_calc_t;
endpackage : mpf_pkg
